// *** core/sep_defines.svh ***
// Constants for the serial EEPROM slave: opcodes, status layout, timing.
// Assumes inclusion by the package and design files by bare name.
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH

`define SEP_OP_WRITE_ENABLE_COMMAND_CMD   8'h06
`define SEP_OP_WRITE_DISABLE_COMMAND_CMD   8'h04
`define SEP_OP_RDST_CMD   8'h05
`define SEP_OP_WRST_CMD   8'h01
`define SEP_OP_READ_MASK  8'hF7
`define SEP_OP_READ_CMD   8'h03
`define SEP_OP_WRITE_CMD  8'h02
`define SEP_ST_BUSY       0
`define SEP_ST_WEL        1
`define SEP_ST_BP_LO      2
`define SEP_ST_BP_HI      3
`define SEP_ST_TOP        8'hF0
`define SEP_ST_WMASK      8'h0C
`define SEP_ADDR_W        9
`define SEP_MEM_DEPTH     512
`define SEP_PAGE_W        4
`define SEP_FIFO_DEPTH    8
`define SEP_PIN_IDLE      5'h13
`define SEP_CLK_MHZ       20
`define SEP_TWC_US        5
`define SEP_TWC_CYC       (`SEP_TWC_US * `SEP_CLK_MHZ)

`endif

// *** core/sep_pkg.sv ***
// Types shared by the serial EEPROM slave files.
// Assumes the defines header sits beside it.
`include "sep_defines.svh"

package sep_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
    logic hold_n;
    logic wp_n;
  } sep_pins_type;

  typedef struct packed {
    logic [`SEP_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } sep_word_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_OPC  = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_OUT  = 6'b001000,
    ST_DIN  = 6'b010000,
    ST_SKIP = 6'b100000
  } sep_state_type;

endpackage : sep_pkg

// *** core/sep_fifo.sv ***
// Parameterised valid/ready FIFO for words awaiting programming.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module sep_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sep_fifo

`default_nettype wire

// *** core/sep_sync.sv ***
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module sep_sync #(
  parameter int               WIDTH   = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  // Reset to the idle pin levels, so no false edge follows reset.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : sep_sync

`default_nettype wire

// *** core/sep_core.sv ***
// Serial EEPROM slave: SPI command decoder, status register and array.
// Assumes pins arrive asynchronously and sck is far slower than ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "sep_defines.svh"

module sep_core #(
  parameter int TWC_CYCLES = `SEP_TWC_CYC
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire sep_pkg::sep_pins_type pins,
  output logic               sdo,
  output logic               sdo_oe,
  output logic               busy,
  output logic               write_latch_flag,
  output logic               protect_range_lo,
  output logic               protect_range_hi
);
  import sep_pkg::*;

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  logic [4:0]    pin_s;
  sep_pins_type  sp;
  logic          sck_d_r;
  logic          cs_d_r;
  logic          wp_d_r;
  logic          rise;
  logic          fall;
  logic          sel_start;
  logic          sel_end;
  logic          held;

  sep_sync #(.WIDTH(5), .RST_VAL(`SEP_PIN_IDLE)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (pins),
    .dout    (pin_s)
  );
  assign sp = sep_pins_type'(pin_s);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
      wp_d_r  <= 1'b1;
    end else begin
      sck_d_r <= sp.sck;
      cs_d_r  <= sp.cs_n;
      wp_d_r  <= sp.wp_n;
    end
  end

  assign held      = !sp.hold_n;
  assign rise      = sp.sck && !sck_d_r && !sp.cs_n && !held;
  assign fall      = !sp.sck && sck_d_r && !sp.cs_n && !held;
  assign sel_start = cs_d_r && !sp.cs_n;
  assign sel_end   = !cs_d_r && sp.cs_n;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_read(input logic [7:0] op);
    return (op & `SEP_OP_READ_MASK) == `SEP_OP_READ_CMD;
  endfunction

  function automatic logic is_write(input logic [7:0] op);
    return (op & `SEP_OP_READ_MASK) == `SEP_OP_WRITE_CMD;
  endfunction

  function automatic logic in_prot(input logic [`SEP_ADDR_W-1:0] a,
                                   input logic [1:0] bp);
    case (bp)
      2'b01:   return a[8:7] == 2'b11;
      2'b10:   return a[8];
      2'b11:   return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Shift state
  // ----------------------------------------
  sep_state_type         st_r;
  logic [2:0]            bit_r;
  logic [7:0]            sh_r;
  logic [7:0]            op_r;
  logic [`SEP_ADDR_W-1:0] addr_r;
  logic [7:0]            tx_r;
  logic [7:0]            rx;
  logic                  byte_done;
  logic [7:0]            status;
  logic [7:0]            mem_r [`SEP_MEM_DEPTH];
  logic                  wel_r;
  logic [1:0]            bp_r;
  logic                  busy_r;
  logic                  arm_r;
  logic                  arm_st_r;
  logic [7:0]            st_data_r;
  logic                  data_seen_r;
  logic [15:0]           twc_r;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  sep_word_type          fifo_out;
  logic                  pgm_pop;
  logic                  pgm_done;
  logic                  start_pgm;

  assign rx        = {sh_r[6:0], sp.sdi};
  assign byte_done = rise && (bit_r == 3'd7);
  assign status    = `SEP_ST_TOP | {4'h0, bp_r, wel_r, busy_r};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_r <= '0;
      sh_r  <= '0;
    end else if (sp.cs_n) begin
      bit_r <= '0;
    end else if (rise) begin
      bit_r <= bit_r + 3'd1;
      sh_r  <= rx;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r   <= ST_IDLE;
      op_r   <= '0;
      addr_r <= '0;
    end else if (sp.cs_n) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (sel_start) begin
            st_r <= ST_OPC;
          end
        end
        ST_OPC: begin
          if (byte_done) begin
            op_r <= rx;
            if (rx == `SEP_OP_RDST_CMD) begin
              st_r <= ST_OUT;
            end else if (busy_r) begin
              st_r <= ST_SKIP;
            end else if (is_read(rx) || is_write(rx)) begin
              addr_r[8] <= rx[3];
              st_r      <= ST_ADDR;
            end else if (rx == `SEP_OP_WRST_CMD) begin
              st_r <= ST_DIN;
            end else begin
              st_r <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            addr_r[7:0] <= rx;
            st_r        <= is_read(op_r) ? ST_OUT : ST_DIN;
          end
        end
        ST_OUT: begin
          if (byte_done && is_read(op_r)) begin
            addr_r <= addr_r + 1'b1;
          end
        end
        ST_DIN: begin
          if (byte_done && is_write(op_r)) begin
            addr_r[3:0] <= addr_r[3:0] + 4'd1;
          end
        end
        default: st_r <= st_r;
      endcase
    end
  end

  // Load on the falling edge so the bit is stable before the host samples.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_r <= '0;
    end else if (st_r == ST_OUT && fall) begin
      if (bit_r == 3'd0) begin
        tx_r <= (op_r == `SEP_OP_RDST_CMD) ? status : mem_r[addr_r];
      end else begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  assign sdo    = tx_r[7];
  assign sdo_oe = (st_r == ST_OUT) && !sp.cs_n && !held;

  // ----------------------------------------
  // Write arming and programming
  // ----------------------------------------
  assign start_pgm = sel_end && arm_r && wp_d_r && sp.wp_n;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_r       <= 1'b0;
      arm_st_r    <= 1'b0;
      st_data_r   <= '0;
      data_seen_r <= 1'b0;
    end else if (sel_start || sel_end) begin
      arm_r       <= 1'b0;
      arm_st_r    <= 1'b0;
      data_seen_r <= 1'b0;
    end else if (!sp.wp_n) begin
      arm_r <= 1'b0;
    end else if (st_r == ST_DIN && byte_done && sp.cs_n == 1'b0 && wel_r) begin
      if (op_r == `SEP_OP_WRST_CMD) begin
        st_data_r <= rx;
        arm_st_r  <= !data_seen_r;
        arm_r     <= !data_seen_r;
      end else if (!in_prot(addr_r, bp_r)) begin
        arm_r <= 1'b1;
      end
      data_seen_r <= 1'b1;
    end
  end

  sep_fifo #(.WIDTH(`SEP_ADDR_W + 8), .DEPTH(`SEP_FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .flush     (sel_start && !busy_r),
    .in_valid  (st_r == ST_DIN && byte_done && is_write(op_r) && wel_r),
    .in_ready  (fifo_in_ready),
    .in_data   ({addr_r, rx}),
    .out_valid (fifo_out_valid),
    .out_ready (pgm_pop),
    .out_data  (fifo_out)
  );

  assign pgm_done = busy_r && (twc_r == 16'd0);
  assign pgm_pop  = pgm_done && fifo_out_valid;

  // The timer runs once per write; queued bytes all commit at its end.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      twc_r  <= '0;
    end else if (start_pgm && !busy_r) begin
      busy_r <= 1'b1;
      twc_r  <= 16'(TWC_CYCLES - 1);
    end else if (busy_r && twc_r != 16'd0) begin
      twc_r <= twc_r - 16'd1;
    end else if (pgm_done && !fifo_out_valid) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (pgm_pop) begin
      mem_r[fifo_out.addr] <= fifo_out.data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bp_r <= '0;
    end else if (start_pgm && !busy_r && arm_st_r) begin
      bp_r <= st_data_r[`SEP_ST_BP_HI:`SEP_ST_BP_LO];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wel_r <= 1'b0;
    end else if (pgm_done && !fifo_out_valid) begin
      wel_r <= 1'b0;
    end else if (sel_end && !busy_r && st_r == ST_SKIP && bit_r == 3'd0) begin
      if (op_r == `SEP_OP_WRITE_ENABLE_COMMAND_CMD) begin
        wel_r <= 1'b1;
      end else if (op_r == `SEP_OP_WRITE_DISABLE_COMMAND_CMD) begin
        wel_r <= 1'b0;
      end
    end
  end

  assign busy             = busy_r;
  assign write_latch_flag = wel_r;
  assign protect_range_lo = bp_r[0];
  assign protect_range_hi = bp_r[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_hold_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
    held |-> !sdo_oe) else $error("output driven during hold");

  a_desel_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sp.cs_n |-> !sdo_oe) else $error("output driven while deselected");

  a_wp_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!busy_r && !sp.wp_n) |=> !busy_r) else $error("write began under wp");

  a_busy_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(busy_r) |-> busy_r [*8]) else $error("busy too short");

  a_wel_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(busy_r) |-> !wel_r) else $error("latch kept after write");

  a_bp_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(bp_r) |-> $past(busy_r) == 1'b0 && busy_r) else $error("bp odd");

  a_status_top: assert property (@(posedge ref_clk) disable iff (sys_rst)
    status[7:4] == 4'hF && status[0] == busy_r) else $error("bad status");

  a_no_arm_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (arm_r && !sp.wp_n) |=> !arm_r) else $error("wp did not abort");
endmodule : sep_core

`default_nettype wire

// *** bench/sep_host.sv ***
// Host controller model that frames commands on the SPI pins.
// Assumes a 20 MHz ref_clk and sck of 400 ns made from it.
`timescale 1ns/1ps
`default_nettype none

module sep_host (
  input  wire logic           ref_clk,
  output var sep_pkg::sep_pins_type pins,
  input  wire logic           sdo,
  input  wire logic           sdo_oe
);
  import sep_pkg::*;

  logic last;
  logic oe_seen;

  // ----------------------------------------
  // Pin tasks
  // ----------------------------------------
  initial begin
    pins = 5'b10011;
    last = 1'b0;
    oe_seen = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic setwp(input logic v);
    @(posedge ref_clk) pins.wp_n <= v;
  endtask

  task automatic sel();
    @(posedge ref_clk) pins.cs_n <= 1'b0;
    oe_seen = 1'b0;
    tick(4);
  endtask

  task automatic desel();
    tick(4);
    @(posedge ref_clk) pins.cs_n <= 1'b1;
    tick(12);
    @(negedge ref_clk);
  endtask

  // A released output is seen as the inverse of its last level.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    logic m;
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk) pins.sdi <= tx[i];
      tick(2);
      @(posedge ref_clk) pins.sck <= 1'b1;
      tick(3);
      @(negedge ref_clk);
      m = sdo_oe ? sdo : ~last;
      oe_seen = oe_seen | sdo_oe;
      rx[i] = m;
      last = m;
      @(posedge ref_clk) pins.sck <= 1'b0;
    end
  endtask

  task automatic pause(output logic oe_bad);
    @(posedge ref_clk) pins.hold_n <= 1'b0;
    oe_bad = 1'b0;
    repeat (4) begin
      @(posedge ref_clk) pins.sdi <= ~pins.sdi;
      tick(3);
      @(negedge ref_clk);
      oe_bad = oe_bad | sdo_oe;
    end
    @(posedge ref_clk) pins.hold_n <= 1'b1;
    tick(4);
  endtask
endmodule // sep_host

`default_nettype wire

// *** bench/test_spi_eeprom_read_protect_hold.sv ***
// Self-checking bench for the serial EEPROM slave.
// Assumes the host model drives all pins; TWC_CYCLES is set to 400.
`timescale 1ns/1ps
`default_nettype none

`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s: expected %h, seen %h", w, e, g); end end

module test_spi_eeprom_read_protect_hold;
  import sep_pkg::*;

  // A long write time lets a status read land inside it.
  localparam int TWC = 400;
  logic         ref_clk = 1'b0;
  logic         sys_rst = 1'b1;
  sep_pins_type pins;
  logic         sdo, sdo_oe, busy, wlf, prl, prh, bad;
  logic   [7:0] s, r;
  int           errors = 0;
  int           n_checks = 0;
  int           cycles = 0;

  sep_core #(.TWC_CYCLES(TWC)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .pins(pins), .sdo(sdo),
    .sdo_oe(sdo_oe), .busy(busy), .write_latch_flag(wlf),
    .protect_range_lo(prl), .protect_range_hi(prh));

  sep_host host (.ref_clk(ref_clk), .pins(pins), .sdo(sdo),
    .sdo_oe(sdo_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.xbyte(op, r);
    host.desel();
  endtask

  task automatic wr(input logic [7:0] op, a, d);
    host.sel();
    host.xbyte(op, r);
    if (op != 8'h01) host.xbyte(a, r);
    host.xbyte(d, r);
    host.desel();
  endtask

  task automatic rdst(output logic [7:0] v);
    host.sel();
    host.xbyte(8'h05, r);
    host.xbyte(8'h00, v);
    host.desel();
  endtask

  task automatic poll(output logic [7:0] v);
    int k;
    k = 0;
    rdst(v);
    while (v[0] !== 1'b0 && k < 20) begin
      rdst(v);
      k++;
    end
    `CHK("ready", 1'b0, v[0])
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    host.tick(3);
    @(negedge ref_clk);
    `CHK("reset", 5'h00, {busy, wlf, prl, prh, sdo_oe})
    rdst(s);
    `CHK("status", 8'hF0, s)
    $display("test reset done");

    cmd(8'h06);
    `CHK("latch set", 1'b1, wlf)
    cmd(8'h04);
    `CHK("latch clr", 1'b0, wlf)
    $display("test latch done");

    cmd(8'h06);
    wr(8'h01, 8'h00, 8'hFF);
    rdst(s);
    `CHK("busy status", 5'h1F, {s[7:4], s[0]})
    poll(s);
    `CHK("status wr", 8'hFC, s)
    $display("test status write done");

    host.setwp(1'b0);
    cmd(8'h06);
    wr(8'h01, 8'h00, 8'h00);
    `CHK("wp low", 3'b011, {busy, prh, prl})
    host.setwp(1'b1);
    cmd(8'h06);
    host.sel();
    host.xbyte(8'h01, r);
    host.xbyte(8'h00, r);
    host.setwp(1'b0);
    host.desel();
    `CHK("wp abort", 3'b011, {busy, prh, prl})
    host.setwp(1'b1);
    cmd(8'h06);
    wr(8'h01, 8'h00, 8'h00);
    host.setwp(1'b0);
    poll(s);
    `CHK("wp late", 8'hF0, s)
    host.setwp(1'b1);
    $display("test protect pin done");

    cmd(8'h06);
    wr(8'h0A, 8'hFF, 8'h5A);
    host.sel();
    host.xbyte(8'h0B, r);
    host.xbyte(8'hFF, r);
    host.xbyte(8'h00, r);
    `CHK("read busy", 1'b0, host.oe_seen)
    host.desel();
    poll(s);
    cmd(8'h06);
    wr(8'h02, 8'h00, 8'hA5);
    poll(s);
    cmd(8'h06);
    host.sel();
    host.xbyte(8'h02, r);
    host.xbyte(8'h1E, r);
    host.xbyte(8'h11, r);
    host.xbyte(8'h22, r);
    host.desel();
    poll(s);
    `CHK("latch after wr", 1'b0, wlf)
    cmd(8'h06);
    wr(8'h01, 8'h00, 8'h04);
    poll(s);
    cmd(8'h06);
    wr(8'h0A, 8'hFF, 8'h00);
    `CHK("block prot", 1'b0, busy)
    wr(8'h01, 8'h00, 8'h00);
    poll(s);
    host.sel();
    host.xbyte(8'h0B, r);
    host.xbyte(8'hFF, r);
    host.xbyte(8'h00, r);
    `CHK("rd first", 8'h5A, r)
    host.xbyte(8'h00, r);
    `CHK("rd wrap", 8'hA5, r)
    host.desel();
    `CHK("rd end", 1'b0, sdo_oe)
    host.sel();
    host.xbyte(8'h03, r);
    host.xbyte(8'h1E, r);
    host.xbyte(8'h00, r);
    `CHK("rd page lo", 8'h11, r)
    host.xbyte(8'h00, r);
    `CHK("rd page hi", 8'h22, r)
    host.desel();
    $display("test array read done");

    host.sel();
    host.xbyte(8'hFF, r);
    host.xbyte(8'h00, r);
    `CHK("bad op", 1'b0, host.oe_seen)
    host.desel();
    host.sel();
    host.xbyte(8'h05, r);
    host.pause(bad);
    `CHK("hold oe", 1'b0, bad)
    host.xbyte(8'h00, s);
    `CHK("hold st", 8'hF0, s)
    host.desel();
    $display("test opcode and hold done");
    conclude();
  end
endmodule // test_spi_eeprom_read_protect_hold

`default_nettype wire
